// *** hw/supervisor_pkg.sv ***
/*
 * Shared constants and types for the supervisor block: clock rate, documented
 * times with their derived cycle counts, reset-sequencer state codes.
 * Assumes a single 100 MHz clock; every derived count is computed here once.
 */
package supervisor_pkg;

    // clock
    localparam int unsigned CLK_PERIOD_NS    = 10;

    // documented times, in their own units
    localparam int unsigned RST_STRETCH_MS   = 130;   // least reset / status pulse
    localparam int unsigned WDOG_TIMEOUT_MS  = 1000;  // least watchdog timeout (1 s)
    localparam int unsigned ALARM_PULSE_US   = 200;   // least interrupt pulse
    localparam int unsigned SENSE_FILTER_US  = 5;     // sense must stay low this long
    localparam int unsigned FAIL_FILTER_US   = 2;     // shorter supply glitches ignored
    localparam int unsigned BUTTON_DEB_NS    = 150;   // least button low time

    // derived cycle counts; least times round up
    localparam int unsigned RST_STRETCH_CYC  =
        (RST_STRETCH_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WDOG_TIMEOUT_CYC =
        (WDOG_TIMEOUT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned ALARM_PULSE_CYC  =
        (ALARM_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SENSE_FILTER_CYC =
        (SENSE_FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned FAIL_FILTER_CYC  =
        (FAIL_FILTER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BUTTON_DEB_CYC   =
        (BUTTON_DEB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // counter width shared by all timers
    localparam int unsigned CNT_W            = 32;

    // reset sequencer
    typedef enum logic [2:0] {
        RST_HOLD    = 3'h1,
        RST_STRETCH = 3'h2,
        RST_RUN     = 3'h4
    } rst_state_t;

endpackage

// *** hw/supervisor_reset_watchdog.sv ***
/*
 * Processor supervisor: reset generation and stretching from a power-fail
 * indication and a debounced pushbutton, a filtered early-warning interrupt
 * pulse from a sense comparator, and a watchdog kicked by falling edges.
 * Assumes comparator decisions arrive as asynchronous digital levels; every
 * pin input is synchronised here. Long counts are parameters for simulation.
 */
// Summary of operation
// R1: filtered supply-fail indication drives reset outputs active at once.
// R2: after supply recovers, including power-up, hold reset at least 130 ms more.
// R3: provide active-low and active-high reset outputs of identical condition.
// R4: pushbutton input is active low and debounced before it requests reset.
// R5: button reset lasts at least 130 ms, timed from button release.
// R6: sense low pulses interrupt output low for at least 200 us.
// R7: sense must stay low about 5 us before the interrupt pulse starts.
// R8: no interrupt pulse until supply has first risen above its trip level.
// R9: watchdog timeout counts only while reset is inactive.
// R10: kick falling edge before timeout restarts watchdog from zero; level does not.
// R11: on watchdog expiry drive status output low for at least 130 ms; the code ends the pulse early when reset asserts.
// R12: host must kick with a falling edge at least once per second.
// R13: interrupt or status outputs wired to button input reset like a press.
// R14: supply-fail glitches under 2 us do not cause reset.
// R15: reset held throughout button low or power-fail; stretch starts afterwards.
module supervisor_reset_watchdog #(
    parameter int unsigned RST_STRETCH_CYC  = supervisor_pkg::RST_STRETCH_CYC,
    parameter int unsigned WDOG_TIMEOUT_CYC = supervisor_pkg::WDOG_TIMEOUT_CYC,
    parameter int unsigned ALARM_PULSE_CYC  = supervisor_pkg::ALARM_PULSE_CYC
) (
    // clock, reset, enable
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    // comparator decisions, asynchronous
    input  wire logic supply_fail_in,
    input  wire logic sense_low_in,
    // host side pins, asynchronous
    input  wire logic manual_button_in_n,
    input  wire logic watchdog_kick_in,
    // outputs to the host
    output logic      reset_out_n,
    output logic      reset_out,
    output logic      sense_alarm_n,
    output logic      watchdog_expired_n
);

    localparam int unsigned CW = supervisor_pkg::CNT_W;

    initial begin
        if (RST_STRETCH_CYC < 1 || WDOG_TIMEOUT_CYC < 1 || ALARM_PULSE_CYC < 1)
            $error("supervisor: cycle counts must be at least one");
    end

    typedef struct packed {
        // two-stage synchronisers; stage one is read only by stage two
        logic                 fail_s1;
        logic                 fail_s2;
        logic                 sense_s1;
        logic                 sense_s2;
        logic                 button_s1;
        logic                 button_s2;
        logic                 kick_s1;
        logic                 kick_s2;
        logic                 kick_prev;
        // filters
        logic [CW-1:0]        fail_cnt;
        logic                 fail_filt;
        logic [CW-1:0]        sense_cnt;
        logic                 sense_filt;
        logic [CW-1:0]        button_cnt;
        logic                 button_low;
        // reset sequencer
        supervisor_pkg::rst_state_t rst_state;
        logic [CW-1:0]        rst_cnt;
        // interrupt
        logic                 alarm_armed;
        logic                 alarm_act;
        logic [CW-1:0]        alarm_cnt;
        // watchdog
        logic [CW-1:0]        wdog_cnt;
        logic                 wdog_act;
        logic [CW-1:0]        wdog_pulse_cnt;
        // outputs
        logic                 reset_n_o;
        logic                 reset_o;
        logic                 alarm_n_o;
        logic                 wdog_n_o;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    localparam logic [CW-1:0] FAIL_LAST   = CW'(supervisor_pkg::FAIL_FILTER_CYC - 1);
    localparam logic [CW-1:0] SENSE_LAST  = CW'(supervisor_pkg::SENSE_FILTER_CYC - 1);
    localparam logic [CW-1:0] BUTTON_LAST = CW'(supervisor_pkg::BUTTON_DEB_CYC - 1);
    localparam logic [CW-1:0] STRETCH_LAST = CW'(RST_STRETCH_CYC - 1);
    localparam logic [CW-1:0] WDOG_LAST   = CW'(WDOG_TIMEOUT_CYC - 1);
    localparam logic [CW-1:0] ALARM_LAST  = CW'(ALARM_PULSE_CYC - 1);
    localparam logic [CW-1:0] CNT_ZERO    = '0;

    always_comb begin
        logic reset_cause;
        logic kick_fall;
        logic running;
        reset_cause = 1'b0;
        kick_fall   = 1'b0;
        running     = 1'b0;
        st_nxt      = st_r;

        st_nxt.fail_s1   = supply_fail_in;
        st_nxt.fail_s2   = st_r.fail_s1;
        st_nxt.sense_s1  = sense_low_in;
        st_nxt.sense_s2  = st_r.sense_s1;
        st_nxt.button_s1 = manual_button_in_n;
        st_nxt.button_s2 = st_r.button_s1;
        st_nxt.kick_s1   = watchdog_kick_in;
        st_nxt.kick_s2   = st_r.kick_s1;
        st_nxt.kick_prev = st_r.kick_s2;

        // supply fail must persist past the glitch window before it counts [R14]
        if (st_r.fail_s2 == st_r.fail_filt) begin
            st_nxt.fail_cnt = CNT_ZERO;
        end else if (st_r.fail_cnt == FAIL_LAST) begin
            st_nxt.fail_cnt  = CNT_ZERO;
            st_nxt.fail_filt = st_r.fail_s2;
        end else begin
            st_nxt.fail_cnt = st_r.fail_cnt + CW'(1);
        end

        // sense low must stay steady for the filter time; rise clears at once [R7]
        if (!st_r.sense_s2) begin
            st_nxt.sense_cnt  = CNT_ZERO;
            st_nxt.sense_filt = 1'b0;
        end else if (!st_r.sense_filt) begin
            if (st_r.sense_cnt == SENSE_LAST) begin
                st_nxt.sense_filt = 1'b1;
            end else begin
                st_nxt.sense_cnt = st_r.sense_cnt + CW'(1);
            end
        end

        // button debounce, both directions; an alarm or status line tied to
        // this pin is treated exactly like a press [R4] [R13]
        if (st_r.button_s2 != st_r.button_low) begin
            st_nxt.button_cnt = CNT_ZERO;
        end else if (st_r.button_cnt == BUTTON_LAST) begin
            st_nxt.button_cnt = CNT_ZERO;
            st_nxt.button_low = !st_r.button_s2;
        end else begin
            st_nxt.button_cnt = st_r.button_cnt + CW'(1);
        end

        // reset sequencer
        reset_cause = st_r.fail_filt || st_r.button_low;
        unique case (st_r.rst_state)
            supervisor_pkg::RST_HOLD: begin
                // held for as long as any cause lasts; stretch starts on release [R15] [R5]
                st_nxt.rst_cnt = CNT_ZERO;
                if (!reset_cause) begin
                    st_nxt.rst_state = supervisor_pkg::RST_STRETCH;
                end
            end
            supervisor_pkg::RST_STRETCH: begin
                if (reset_cause) begin
                    st_nxt.rst_state = supervisor_pkg::RST_HOLD;
                end else if (st_r.rst_cnt == STRETCH_LAST) begin
                    st_nxt.rst_state = supervisor_pkg::RST_RUN; // [R2] [R5]
                end else begin
                    st_nxt.rst_cnt = st_r.rst_cnt + CW'(1);
                end
            end
            supervisor_pkg::RST_RUN: begin
                if (reset_cause) begin
                    st_nxt.rst_state = supervisor_pkg::RST_HOLD; // [R1]
                end
            end
            default: begin
                st_nxt.rst_state = supervisor_pkg::RST_HOLD;
            end
        endcase
        running = (st_nxt.rst_state == supervisor_pkg::RST_RUN);
        st_nxt.reset_n_o = running;  // [R3]
        st_nxt.reset_o   = !running; // [R3]

        // interrupt armed once the supply has first passed its trip level [R8]
        if (!st_r.fail_filt) begin
            st_nxt.alarm_armed = 1'b1;
        end
        // one pulse per filtered low event, of fixed least length [R6]
        if (st_r.alarm_act) begin
            if (st_r.alarm_cnt == ALARM_LAST) begin
                st_nxt.alarm_act = 1'b0;
                st_nxt.alarm_cnt = CNT_ZERO;
            end else begin
                st_nxt.alarm_cnt = st_r.alarm_cnt + CW'(1);
            end
        end else if (st_r.alarm_armed && st_nxt.sense_filt && !st_r.sense_filt) begin
            st_nxt.alarm_act = 1'b1; // [R6] [R8]
            st_nxt.alarm_cnt = CNT_ZERO;
        end
        st_nxt.alarm_n_o = !st_nxt.alarm_act;

        // watchdog: idle under reset, restarted only by a falling kick edge
        kick_fall = st_r.kick_prev && !st_r.kick_s2;
        if (st_r.rst_state != supervisor_pkg::RST_RUN) begin
            st_nxt.wdog_cnt       = CNT_ZERO; // [R9]
            st_nxt.wdog_act       = 1'b0;
            st_nxt.wdog_pulse_cnt = CNT_ZERO;
        end else if (st_r.wdog_act) begin
            // status pulse runs its full length unless reset asserts; kicks meanwhile are ignored [R11]
            if (st_r.wdog_pulse_cnt == STRETCH_LAST) begin
                st_nxt.wdog_act       = 1'b0;
                st_nxt.wdog_pulse_cnt = CNT_ZERO;
                st_nxt.wdog_cnt       = CNT_ZERO;
            end else begin
                st_nxt.wdog_pulse_cnt = st_r.wdog_pulse_cnt + CW'(1);
            end
        end else if (kick_fall) begin
            st_nxt.wdog_cnt = CNT_ZERO; // [R10] [R12]
        end else if (st_r.wdog_cnt == WDOG_LAST) begin
            st_nxt.wdog_act = 1'b1;     // [R11]
            st_nxt.wdog_cnt = CNT_ZERO;
        end else begin
            st_nxt.wdog_cnt = st_r.wdog_cnt + CW'(1); // [R9]
        end
        st_nxt.wdog_n_o = !st_nxt.wdog_act;
    end

    // reset starts in hold so that power-up gets the full stretch [R2]
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            st_r             <= '0;
            st_r.fail_s1     <= 1'b1;
            st_r.fail_s2     <= 1'b1;
            st_r.fail_filt   <= 1'b1;
            st_r.button_s1   <= 1'b1;
            st_r.button_s2   <= 1'b1;
            st_r.kick_s1     <= 1'b1;
            st_r.kick_s2     <= 1'b1;
            st_r.kick_prev   <= 1'b1;
            st_r.rst_state   <= supervisor_pkg::RST_HOLD;
            st_r.reset_n_o   <= 1'b0;
            st_r.reset_o     <= 1'b1;
            st_r.alarm_n_o   <= 1'b1;
            st_r.wdog_n_o    <= 1'b1;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    assign reset_out_n        = st_r.reset_n_o;
    assign reset_out          = st_r.reset_o;
    assign sense_alarm_n      = st_r.alarm_n_o;
    assign watchdog_expired_n = st_r.wdog_n_o;

endmodule

// *** verif/supervisor_checker.sv ***
/* Port checker for the supervisor block, bound to its top module.
   Assumes clk_en is held high, so its run counters advance every edge. */
module supervisor_checker #(
    parameter int unsigned RST_STRETCH_CYC  = 50,
    parameter int unsigned WDOG_TIMEOUT_CYC = 200,
    parameter int unsigned ALARM_PULSE_CYC  = 30
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic supply_fail_in,
    input wire logic sense_low_in,
    input wire logic manual_button_in_n,
    input wire logic watchdog_kick_in,
    input wire logic reset_out_n,
    input wire logic reset_out,
    input wire logic sense_alarm_n,
    input wire logic watchdog_expired_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned fail_r, btn_r, quiet_r, sense_r, clear_r, run_r, alarm_r, stat_r;
    logic        armed_r;
    logic        kick_r;
    // raw-pin run lengths give lower bounds; the sync flops only add delay
    always_ff @(posedge sys_clk) begin
        kick_r <= watchdog_kick_in;
        if (sys_rst) begin
            {fail_r, btn_r, quiet_r, sense_r, clear_r, run_r, alarm_r, stat_r} <= '0;
            armed_r <= 1'h0;
        end else begin
            fail_r  <= supply_fail_in ? fail_r + 1 : 0;
            btn_r   <= manual_button_in_n ? 0 : btn_r + 1;
            sense_r <= sense_low_in ? sense_r + 1 : 0;
            quiet_r <= (supply_fail_in | !manual_button_in_n) ? 0 : quiet_r + 1;
            clear_r <= supply_fail_in ? 0 : clear_r + 1;
            armed_r <= armed_r | (clear_r >= 195);
            run_r   <= (!reset_out_n | (kick_r & !watchdog_kick_in)) ? 0 : run_r + 1;
            alarm_r <= sense_alarm_n ? 0 : alarm_r + 1;
            stat_r  <= watchdog_expired_n ? 0 : stat_r + 1;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    a_reset_polarity: assert property (reset_out == !reset_out_n)
        else $error("reset outputs disagree");
    a_fail_forces_reset: assert property (fail_r >= 210 |-> !reset_out_n)
        else $error("supply fail left reset released");
    a_reset_cause: assert property ($fell(reset_out_n) |-> fail_r >= 195 || btn_r >= 12)
        else $error("reset asserted without a lasting cause");
    a_stretch_min: assert property ($rose(reset_out_n) |-> quiet_r >= RST_STRETCH_CYC)
        else $error("reset released too soon after its cause");
    a_alarm_width: assert property ($rose(sense_alarm_n) |-> alarm_r == ALARM_PULSE_CYC)
        else $error("interrupt pulse length wrong");
    a_alarm_filter: assert property ($fell(sense_alarm_n) |-> sense_r >= 500)
        else $error("interrupt on a short sense excursion");
    a_alarm_armed: assert property (!armed_r |-> sense_alarm_n)
        else $error("interrupt before supply reached its trip level");
    a_wdog_interval: assert property ($fell(watchdog_expired_n) |-> run_r + 2 >= WDOG_TIMEOUT_CYC)
        else $error("watchdog expired early");
    a_status_width: assert property ($rose(watchdog_expired_n) && reset_out_n |-> stat_r == RST_STRETCH_CYC)
        else $error("watchdog status pulse length wrong");
    c_alarm: cover property ($fell(sense_alarm_n));
    c_expiry: cover property ($fell(watchdog_expired_n));
    c_release: cover property ($rose(reset_out_n));
endmodule

bind supervisor_reset_watchdog supervisor_checker #(
    .RST_STRETCH_CYC(RST_STRETCH_CYC), .WDOG_TIMEOUT_CYC(WDOG_TIMEOUT_CYC),
    .ALARM_PULSE_CYC(ALARM_PULSE_CYC)
) supervisor_checker_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .supply_fail_in(supply_fail_in),
    .sense_low_in(sense_low_in), .manual_button_in_n(manual_button_in_n),
    .watchdog_kick_in(watchdog_kick_in), .reset_out_n(reset_out_n), .reset_out(reset_out),
    .sense_alarm_n(sense_alarm_n), .watchdog_expired_n(watchdog_expired_n)
);

// *** verif/host_model.sv ***
/* Host processor model: kicks the watchdog while reset is released and can
   wire the status outputs onto the button line. Assumes the bench clock. */
module host_model #(
    parameter int unsigned KICK_PER = 100
) (
    input  wire logic sys_clk,
    input  wire logic kick_en,
    input  wire logic tie_en,
    input  wire logic button_n,
    input  wire logic reset_out_n,
    input  wire logic sense_alarm_n,
    input  wire logic watchdog_expired_n,
    output logic      watchdog_kick_in,
    output logic      manual_button_in_n
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned phase_r = 0;
    initial watchdog_kick_in = 1'h1;
    // a host held in reset runs no code, so it cannot kick
    always @(posedge sys_clk) begin
        phase_r <= (phase_r + 1 >= KICK_PER) ? 0 : phase_r + 1;
        if (!kick_en)
            watchdog_kick_in <= 1'h0;
        else if (reset_out_n)
            watchdog_kick_in <= (phase_r >= 4);
    end
    // open-drain status lines pulling the button input low
    assign manual_button_in_n = button_n & (!tie_en | (sense_alarm_n & watchdog_expired_n));
endmodule

// *** verif/tb_top.sv ***
/* Self-checking bench for the supervisor with the host model on its far side.
   Assumes shortened stretch, timeout and pulse counts, set below. */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int STR = 50;
    localparam int WDT = 200;
    localparam int ALP = 30;
    localparam int FAIL_F = 200;
    localparam int BTN_F = 15;
    localparam int SENSE_F = 500;
    logic sys_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic supply_fail_in = 1'h1;
    logic sense_low_in = 1'h1;
    logic button_n = 1'h1;
    logic kick_en = 1'h0;
    logic tie_en = 1'h0;
    wire logic manual_button_in_n, watchdog_kick_in, reset_out_n, reset_out;
    wire logic sense_alarm_n, watchdog_expired_n;
    int miscompares = 0;
    int cmp_count = 0;
    supervisor_reset_watchdog #(.RST_STRETCH_CYC(STR), .WDOG_TIMEOUT_CYC(WDT),
        .ALARM_PULSE_CYC(ALP)) supervisor_reset_watchdog_inst (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'h1), .supply_fail_in(supply_fail_in),
        .sense_low_in(sense_low_in), .manual_button_in_n(manual_button_in_n),
        .watchdog_kick_in(watchdog_kick_in), .reset_out_n(reset_out_n), .reset_out(reset_out),
        .sense_alarm_n(sense_alarm_n), .watchdog_expired_n(watchdog_expired_n));
    host_model #(.KICK_PER(100)) host_model_inst (
        .sys_clk(sys_clk), .kick_en(kick_en), .tie_en(tie_en), .button_n(button_n),
        .reset_out_n(reset_out_n), .sense_alarm_n(sense_alarm_n),
        .watchdog_expired_n(watchdog_expired_n), .watchdog_kick_in(watchdog_kick_in),
        .manual_button_in_n(manual_button_in_n));
    initial forever #5 sys_clk = ~sys_clk;
    function automatic logic pick(int sel);
        return (sel == 0) ? reset_out_n : (sel == 1) ? sense_alarm_n : watchdog_expired_n;
    endfunction
    function automatic logic in_window(int n, int lo);
        return (n >= lo) && (n <= lo + 10);
    endfunction
    function automatic logic quiet(int len, int filt);
        return len < filt;
    endfunction
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        cmp_count++;
        if (exp !== got) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // outputs are read at the falling edge, well clear of their updates
    task automatic wait_for(int sel, logic val, int max, output int n);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (pick(sel) !== val && n < max);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        int n;
        int len;
        n = $urandom(32'hAC150CEE);
        cyc(4);
        sys_rst <= 1'h0;
        kick_en <= 1'h1;
        wait_for(1, 1'h0, 600, n);
        check("early alarm", 600, n);
        cyc(1);
        supply_fail_in <= 1'h0;
        sense_low_in <= 1'h0;
        wait_for(0, 1'h1, 600, n);
        check("powerup release", 1, in_window(n, FAIL_F + STR));
        check("active high reset", 0, reset_out);
        $display("test powerup finished");
        repeat (4) begin
            cyc(1);
            len = 20 + $urandom % 150;
            supply_fail_in <= 1'h1;
            cyc(len);
            supply_fail_in <= 1'h0;
            cyc(260);
            wait_for(0, 1'h1, 1, n);
            check("glitch reset", quiet(len, FAIL_F), reset_out_n);
        end
        cyc(1);
        len = 300 + $urandom % 100;
        supply_fail_in <= 1'h1;
        cyc(len);
        wait_for(0, 1'h0, 1, n);
        check("fail reset", quiet(len, FAIL_F), reset_out_n);
        cyc(1);
        supply_fail_in <= 1'h0;
        wait_for(0, 1'h1, 600, n);
        check("fail release", 1, in_window(n, FAIL_F + STR));
        check("wdog idle in reset", 1, watchdog_expired_n);
        $display("test supply finished");
        cyc(1);
        button_n <= 1'h0;
        cyc(5);
        button_n <= 1'h1;
        wait_for(0, 1'h0, 40, n);
        check("button bounce", quiet(5, BTN_F), reset_out_n);
        cyc(1);
        button_n <= 1'h0;
        wait_for(0, 1'h0, 30, n);
        check("press reset", 1, n < 30);
        cyc(20 + $urandom % 40);
        button_n <= 1'h1;
        wait_for(0, 1'h1, 200, n);
        check("press stretch", 1, in_window(n, BTN_F + STR));
        $display("test button finished");
        cyc(1);
        sense_low_in <= 1'h1;
        cyc(100 + $urandom % 350);
        sense_low_in <= 1'h0;
        wait_for(1, 1'h0, 60, n);
        check("short sense", 60, n);
        cyc(1);
        sense_low_in <= 1'h1;
        wait_for(1, 1'h0, 600, n);
        check("sense filter", 1, in_window(n, SENSE_F));
        wait_for(1, 1'h1, 100, n);
        check("alarm width", ALP, n);
        wait_for(1, 1'h0, 100, n);
        check("single alarm", 100, n);
        cyc(1);
        sense_low_in <= 1'h0;
        $display("test sense finished");
        wait_for(2, 1'h0, 800, n);
        check("kicked wdog", 800, n);
        cyc(1);
        kick_en <= 1'h0;
        wait_for(2, 1'h0, 400, n);
        check("wdog expiry", 1, (n + 5 >= WDT) && (n <= WDT + 10));
        wait_for(2, 1'h1, 200, n);
        check("status width", STR, n);
        cyc(1);
        tie_en <= 1'h1;
        wait_for(0, 1'h0, 400, n);
        check("status to reset", 1, n <= WDT + 40);
        cyc(1);
        tie_en <= 1'h0;
        kick_en <= 1'h1;
        wait_for(0, 1'h1, 400, n);
        $display("test watchdog finished");
        cyc(1);
        sys_rst <= 1'h1;
        cyc(4);
        sys_rst <= 1'h0;
        wait_for(0, 1'h1, 600, n);
        check("rerelease", 1, in_window(n, FAIL_F + STR));
        $display("test rereset finished");
        report_and_stop();
    end
    // the sequence needs some 6000 cycles; the limit leaves wide room
    initial begin
        #500000;
        miscompares++;
        report_and_stop();
    end
endmodule
